// ==== design/conveyor_out_regs.svh ====
// register offsets, field positions, reset values and limits of the output bank
`ifndef CONVEYOR_OUT_REGS_SVH
`define CONVEYOR_OUT_REGS_SVH

// word offsets on the controller write port
`define ADDR_STOP_GROUP     16'h0708
`define ADDR_LEFT_PORT      16'h0709
`define ADDR_RIGHT_PORT     16'h070a
`define ADDR_SENSOR_OUT     16'h070b
`define ADDR_LEFT_RUN       16'h070c
`define ADDR_LEFT_BRAKE     16'h070d
`define ADDR_LEFT_FOLLOW    16'h070e
`define ADDR_RIGHT_RUN      16'h070f
`define ADDR_RIGHT_BRAKE    16'h0710
`define ADDR_RIGHT_FOLLOW   16'h0711
`define ADDR_LEFT_SPEED     16'h0712
`define ADDR_RIGHT_SPEED    16'h0713
`define ADDR_LEFT_ACCEL     16'h0714
`define ADDR_LEFT_DECEL     16'h0715
`define ADDR_RIGHT_ACCEL    16'h0716
`define ADDR_RIGHT_DECEL    16'h0717
`define ADDR_FAULT_CLEAR    16'h0718

// field positions
`define BIT_PORT_DIO        15
`define BIT_LEFT_PIN4       1
`define BIT_LEFT_PIN3       2
`define BIT_RIGHT_PIN2      0
`define BIT_RIGHT_PIN3      2
`define BIT_AUX_LEFT_LVL    0
`define BIT_AUX_RIGHT_LVL   1
`define BIT_AUX_LEFT_EN     5
`define BIT_AUX_RIGHT_EN    6
`define BIT_RUN             0
`define BIT_REVERSE         8
`define BIT_DIN_LOW         12
`define BIT_DIN_HIGH        14

// value limits
`define ACCEL_MIN           16'h001e
`define DECEL_MIN           16'h0001
`define RAMP_MAX            16'h2710
`define SPEED_MIN           16'h0001
`define SPEED_MAX           16'hffff

// reset values
`define SPEED_RST           16'h0000
`define ACCEL_RST           16'h001e
`define DECEL_RST           16'h001e

`endif

// ==== design/conveyor_out_pkg.sv ====
// types for the conveyor motor output bank
package conveyor_out_pkg;

    typedef enum logic [15:0] {
        STOP_NONE  = 16'h0000,
        STOP_ENTER = 16'h0001,
        STOP_CLEAR = 16'h0002
    } stop_cmd_e;

    typedef enum logic [1:0] {
        BRAKE_CONFIGURED = 2'h0,
        BRAKE_STANDARD   = 2'h1,
        BRAKE_COAST      = 2'h2,
        BRAKE_SERVO      = 2'h3
    } brake_e;

    typedef enum logic [1:0] {
        FOLLOW_IGNORE   = 2'h0,
        FOLLOW_OFF      = 2'h1,
        FOLLOW_MIRROR   = 2'h2,
        FOLLOW_OPPOSITE = 2'h3
    } follower_e;

    typedef logic [15:0] word_t;

endpackage : conveyor_out_pkg

// ==== design/hold_nonzero_word.sv ====
// word register that keeps its last accepted nonzero value
`timescale 1ns/1ps
`default_nettype none

module hold_nonzero_word #(
    parameter logic [15:0] MIN_VAL = 16'h0001,
    parameter logic [15:0] MAX_VAL = 16'hffff,
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_sync_n,
    // write side
    input  wire logic        wr,
    input  wire logic [15:0] wr_data,
    // held value
    output var  logic [15:0] value_reg
);

    logic accept;

    // zero and out of range codes keep the old value
    assign accept = wr && (wr_data != 16'h0000) && (wr_data >= MIN_VAL) && (wr_data <= MAX_VAL);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            value_reg <= RST_VAL;
        end else if (accept) begin
            value_reg <= wr_data;
        end
    end

endmodule : hold_nonzero_word

`default_nettype wire

// ==== design/conveyor_motor_output_regs.sv ====
// output register bank of a two motor conveyor roller controller
// Behaviour
// - motor-port input status is passed on only in digital mode and only bits 12 and 14.
// - all words are 16 bits and are written by the controller only in controller mode.
// - stop code 0 does nothing, 1 enters the stopped state and 2 clears it.
// - left port word bit 1 and bit 2 drive the two left port outputs.
// - right port word bit 0 and bit 2 drive the two right port outputs.
// - bit 15 of a port word selects motor drive when clear and digital outputs when set.
// - sensor word bits 0,1 are aux levels and bits 5,6 enable the aux pins as outputs.
// - run word bit 0 commands run and bit 8 reverses the configured direction.
// - brake code selects configured, standard, coast or servo; left takes only 0 and 1.
// - follower code 0 is ignored, 1 independent, 2 mirror, 3 opposite.
// - speed setpoint is a plain integer in mm/s or rpm times ten.
// - a zero speed write keeps the last nonzero setpoint.
// - acceleration stays within 30 to 10000 and deceleration within 1 to 10000.
// - a zero ramp write keeps the last nonzero ramp.
// - fault clear 1 sends a reset request and 0 ends it.
`timescale 1ns/1ps
`default_nettype none
`include "conveyor_out_regs.svh"

module conveyor_motor_output_regs
    import conveyor_out_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // controller write port
    input  wire logic        plc_mode,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_addr,
    input  wire logic [15:0] wr_data,
    // motor port input pins
    input  wire logic [15:0] left_port_din,
    input  wire logic [15:0] right_port_din,
    // stop group
    output var  logic        stop_group_stopped_reg,
    // motor ports used as digital outputs
    output var  logic        left_port_dio_reg,
    output var  logic        left_pin4_out_reg,
    output var  logic        left_pin3_out_reg,
    output var  logic        right_port_dio_reg,
    output var  logic        right_pin2_out_reg,
    output var  logic        right_pin3_out_reg,
    output var  logic [1:0]  left_din_valid_reg,
    output var  logic [1:0]  right_din_valid_reg,
    // sensor port aux pins
    output var  logic        aux_left_out_reg,
    output var  logic        aux_left_oe_n_reg,
    output var  logic        aux_right_out_reg,
    output var  logic        aux_right_oe_n_reg,
    // motor commands
    output var  logic        left_run_reg,
    output var  logic        left_reverse_reg,
    output var  logic        right_run_reg,
    output var  logic        right_reverse_reg,
    output var  brake_e      left_brake_reg,
    output var  brake_e      right_brake_reg,
    output var  follower_e   left_follow_reg,
    output var  follower_e   right_follow_reg,
    output wire logic [15:0] left_speed,
    output wire logic [15:0] right_speed,
    output wire logic [15:0] left_accel,
    output wire logic [15:0] left_decel,
    output wire logic [15:0] right_accel,
    output wire logic [15:0] right_decel,
    output var  logic        fault_clear_reg
);

    logic        rst_meta_n;
    logic        rst_sync_n;
    logic [15:0] left_din_meta;
    logic [15:0] left_din_sync;
    logic [15:0] right_din_meta;
    logic [15:0] right_din_sync;
    logic        wr_ok;
    logic [5:0]  ramp_wr;
    logic [15:0] ramp_val [6];

    // true when a write hits the given offset
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
        hit = (addr == target);
    endfunction : hit

    // true when the word is a small code not above the limit
    function automatic logic code_ok(input logic [15:0] data, input logic [15:0] limit);
        code_ok = (data <= limit);
    endfunction : code_ok

    // reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    assign wr_ok = wr_en && plc_mode;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stop_group_stopped_reg <= 1'b0;
        end else if (wr_ok && hit(wr_addr, `ADDR_STOP_GROUP)) begin
            if (wr_data == STOP_ENTER) begin
                stop_group_stopped_reg <= 1'b1;
            end else if (wr_data == STOP_CLEAR) begin
                stop_group_stopped_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_port_dio_reg <= 1'b0;
            left_pin4_out_reg <= 1'b0;
            left_pin3_out_reg <= 1'b0;
        end else if (wr_ok && hit(wr_addr, `ADDR_LEFT_PORT)) begin
            left_port_dio_reg <= wr_data[`BIT_PORT_DIO];
            left_pin4_out_reg <= wr_data[`BIT_PORT_DIO] & wr_data[`BIT_LEFT_PIN4];
            left_pin3_out_reg <= wr_data[`BIT_PORT_DIO] & wr_data[`BIT_LEFT_PIN3];
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            right_port_dio_reg <= 1'b0;
            right_pin2_out_reg <= 1'b0;
            right_pin3_out_reg <= 1'b0;
        end else if (wr_ok && hit(wr_addr, `ADDR_RIGHT_PORT)) begin
            right_port_dio_reg <= wr_data[`BIT_PORT_DIO];
            right_pin2_out_reg <= wr_data[`BIT_PORT_DIO] & wr_data[`BIT_RIGHT_PIN2];
            right_pin3_out_reg <= wr_data[`BIT_PORT_DIO] & wr_data[`BIT_RIGHT_PIN3];
        end
    end

    // motor port input pins synchronised
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_din_meta  <= 16'h0000;
            left_din_sync  <= 16'h0000;
            right_din_meta <= 16'h0000;
            right_din_sync <= 16'h0000;
        end else begin
            left_din_meta  <= left_port_din;
            left_din_sync  <= left_din_meta;
            right_din_meta <= right_port_din;
            right_din_sync <= right_din_meta;
        end
    end

    // only two input bits, only in digital mode
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_din_valid_reg  <= 2'b00;
            right_din_valid_reg <= 2'b00;
        end else begin
            left_din_valid_reg  <= left_port_dio_reg ?
                {left_din_sync[`BIT_DIN_HIGH], left_din_sync[`BIT_DIN_LOW]} : 2'b00;
            right_din_valid_reg <= right_port_dio_reg ?
                {right_din_sync[`BIT_DIN_HIGH], right_din_sync[`BIT_DIN_LOW]} : 2'b00;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aux_left_out_reg   <= 1'b0;
            aux_left_oe_n_reg  <= 1'b1;
            aux_right_out_reg  <= 1'b0;
            aux_right_oe_n_reg <= 1'b1;
        end else if (wr_ok && hit(wr_addr, `ADDR_SENSOR_OUT)) begin
            aux_left_out_reg   <= wr_data[`BIT_AUX_LEFT_LVL];
            aux_left_oe_n_reg  <= ~wr_data[`BIT_AUX_LEFT_EN];
            aux_right_out_reg  <= wr_data[`BIT_AUX_RIGHT_LVL];
            aux_right_oe_n_reg <= ~wr_data[`BIT_AUX_RIGHT_EN];
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_run_reg      <= 1'b0;
            left_reverse_reg  <= 1'b0;
            right_run_reg     <= 1'b0;
            right_reverse_reg <= 1'b0;
        end else if (wr_ok) begin
            if (hit(wr_addr, `ADDR_LEFT_RUN)) begin
                left_run_reg     <= wr_data[`BIT_RUN];
                left_reverse_reg <= wr_data[`BIT_REVERSE];
            end
            if (hit(wr_addr, `ADDR_RIGHT_RUN)) begin
                right_run_reg     <= wr_data[`BIT_RUN];
                right_reverse_reg <= wr_data[`BIT_REVERSE];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_brake_reg  <= BRAKE_CONFIGURED;
            right_brake_reg <= BRAKE_CONFIGURED;
        end else if (wr_ok) begin
            if (hit(wr_addr, `ADDR_LEFT_BRAKE) && code_ok(wr_data, 16'h0001)) begin
                left_brake_reg <= brake_e'(wr_data[1:0]);
            end
            if (hit(wr_addr, `ADDR_RIGHT_BRAKE) && code_ok(wr_data, 16'h0003)) begin
                right_brake_reg <= brake_e'(wr_data[1:0]);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_follow_reg  <= FOLLOW_OFF;
            right_follow_reg <= FOLLOW_OFF;
        end else if (wr_ok && wr_data != 16'h0000 && code_ok(wr_data, 16'h0003)) begin
            if (hit(wr_addr, `ADDR_LEFT_FOLLOW)) begin
                left_follow_reg <= follower_e'(wr_data[1:0]);
            end
            if (hit(wr_addr, `ADDR_RIGHT_FOLLOW)) begin
                right_follow_reg <= follower_e'(wr_data[1:0]);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fault_clear_reg <= 1'b0;
        end else if (wr_ok && hit(wr_addr, `ADDR_FAULT_CLEAR) && code_ok(wr_data, 16'h0001)) begin
            fault_clear_reg <= wr_data[0];
        end
    end

    assign ramp_wr[0] = wr_ok && hit(wr_addr, `ADDR_LEFT_SPEED);
    assign ramp_wr[1] = wr_ok && hit(wr_addr, `ADDR_RIGHT_SPEED);
    assign ramp_wr[2] = wr_ok && hit(wr_addr, `ADDR_LEFT_ACCEL);
    assign ramp_wr[3] = wr_ok && hit(wr_addr, `ADDR_RIGHT_ACCEL);
    assign ramp_wr[4] = wr_ok && hit(wr_addr, `ADDR_LEFT_DECEL);
    assign ramp_wr[5] = wr_ok && hit(wr_addr, `ADDR_RIGHT_DECEL);

    for (genvar g = 0; g < 6; g++) begin : g_word
        localparam logic [15:0] MIN_V = (g < 2) ? `SPEED_MIN : (g < 4) ? `ACCEL_MIN : `DECEL_MIN;
        localparam logic [15:0] MAX_V = (g < 2) ? `SPEED_MAX : `RAMP_MAX;
        localparam logic [15:0] RST_V = (g < 2) ? `SPEED_RST : (g < 4) ? `ACCEL_RST : `DECEL_RST;
        hold_nonzero_word #(
            .MIN_VAL (MIN_V),
            .MAX_VAL (MAX_V),
            .RST_VAL (RST_V)
        ) u_word (
            .mclk       (mclk),
            .rst_sync_n (rst_sync_n),
            .wr         (ramp_wr[g]),
            .wr_data    (wr_data),
            .value_reg  (ramp_val[g])
        );
    end

    assign left_speed  = ramp_val[0];
    assign right_speed = ramp_val[1];
    assign left_accel  = ramp_val[2];
    assign right_accel = ramp_val[3];
    assign left_decel  = ramp_val[4];
    assign right_decel = ramp_val[5];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    property p_stop_enter;
        wr_ok && wr_addr == `ADDR_STOP_GROUP && wr_data == 16'h0001 |=> stop_group_stopped_reg;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop enter not taken");

    property p_stop_hold;
        wr_ok && wr_addr == `ADDR_STOP_GROUP && wr_data > 16'h0002 |=> $stable(stop_group_stopped_reg);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("bad stop code acted");

    property p_left_pins;
        wr_ok && wr_addr == `ADDR_LEFT_PORT |=>
            left_pin4_out_reg == ($past(wr_data[15]) & $past(wr_data[1])) &&
            left_pin3_out_reg == ($past(wr_data[15]) & $past(wr_data[2]));
    endproperty
    a_left_pins: assert property (p_left_pins) else $error("left port pins wrong");

    property p_right_pins;
        wr_ok && wr_addr == `ADDR_RIGHT_PORT |=>
            right_pin2_out_reg == ($past(wr_data[15]) & $past(wr_data[0])) &&
            right_port_dio_reg == $past(wr_data[15]);
    endproperty
    a_right_pins: assert property (p_right_pins) else $error("right port pins wrong");

    property p_motor_use;
        !left_port_dio_reg |-> !left_pin4_out_reg && !left_pin3_out_reg;
    endproperty
    a_motor_use: assert property (p_motor_use) else $error("pin driven in motor use");

    property p_din_mode;
        left_din_valid_reg != 2'b00 |-> $past(left_port_dio_reg);
    endproperty
    a_din_mode: assert property (p_din_mode) else $error("input passed outside digital mode");

    property p_aux;
        wr_ok && wr_addr == `ADDR_SENSOR_OUT |=>
            aux_left_oe_n_reg == !$past(wr_data[5]) && aux_right_out_reg == $past(wr_data[1]);
    endproperty
    a_aux: assert property (p_aux) else $error("aux pin control wrong");

    property p_run;
        wr_ok && wr_addr == `ADDR_LEFT_RUN |=>
            left_run_reg == $past(wr_data[0]) && left_reverse_reg == $past(wr_data[8]);
    endproperty
    a_run: assert property (p_run) else $error("left run word wrong");

    property p_left_brake;
        wr_ok && wr_addr == `ADDR_LEFT_BRAKE && wr_data > 16'h0001 |=> $stable(left_brake_reg);
    endproperty
    a_left_brake: assert property (p_left_brake) else $error("left brake took bad code");

    property p_follow_zero;
        wr_ok && wr_addr == `ADDR_RIGHT_FOLLOW && wr_data == 16'h0000 |=> $stable(right_follow_reg);
    endproperty
    a_follow_zero: assert property (p_follow_zero) else $error("follower zero acted");

    property p_speed_set;
        wr_ok && wr_addr == `ADDR_LEFT_SPEED && wr_data != 16'h0000 |=> left_speed == $past(wr_data);
    endproperty
    a_speed_set: assert property (p_speed_set) else $error("speed not stored");

    property p_speed_zero;
        wr_ok && wr_addr == `ADDR_RIGHT_SPEED && wr_data == 16'h0000 |=> $stable(right_speed);
    endproperty
    a_speed_zero: assert property (p_speed_zero) else $error("zero speed overwrote");

    property p_accel_range;
        left_accel >= 16'h001e && left_accel <= 16'h2710 && right_decel <= 16'h2710;
    endproperty
    a_accel_range: assert property (p_accel_range) else $error("ramp out of range");

    property p_ramp_zero;
        wr_ok && wr_addr == `ADDR_LEFT_DECEL && wr_data == 16'h0000 |=> $stable(left_decel);
    endproperty
    a_ramp_zero: assert property (p_ramp_zero) else $error("zero ramp overwrote");

    property p_fault;
        wr_ok && wr_addr == `ADDR_FAULT_CLEAR && wr_data == 16'h0001 |=> fault_clear_reg [*1];
    endproperty
    a_fault: assert property (p_fault) else $error("fault reset not sent");

    property p_mode_gate;
        wr_en && !plc_mode |=> $stable(left_run_reg) && $stable(stop_group_stopped_reg);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("write taken outside mode");

    c_stop_cycle: cover property (stop_group_stopped_reg ##[1:50] !stop_group_stopped_reg);
    c_dio_input: cover property (left_port_dio_reg && left_din_valid_reg == 2'b11);
    c_reverse_run: cover property (right_run_reg && right_reverse_reg && right_follow_reg == FOLLOW_OPPOSITE);

endmodule : conveyor_motor_output_regs

`default_nettype wire

// ==== sim/plc_model.sv ====
// controller side model: writes output words and drives motor-port pins
`timescale 1ns/1ps
`default_nettype none

module plc_model (
    // clock
    input  wire logic        mclk,
    // controller write port
    output var  logic        plc_mode,
    output var  logic        wr_en,
    output var  logic [15:0] wr_addr,
    output var  logic [15:0] wr_data,
    // motor port pins
    output var  logic [15:0] left_port_din,
    output var  logic [15:0] right_port_din
);
    initial begin
        plc_mode       = 1'b1;
        wr_en          = 1'b0;
        wr_addr        = 16'h0000;
        wr_data        = 16'h0000;
        left_port_din  = 16'h0000;
        right_port_din = 16'h0000;
    end

    // ramp range is kept by callers except refusal cases
    task automatic write_word(input logic [15:0] addr, input logic [15:0] data);
        wr_en   = 1'b1;
        wr_addr = addr;
        wr_data = data;
        @(negedge mclk);
    endtask : write_word

    task automatic idle();
        wr_en   = 1'b0;
        wr_addr = ~wr_addr;
        wr_data = ~wr_data;
        @(negedge mclk);
    endtask : idle

    task automatic set_mode(input logic mode);
        plc_mode = mode;
    endtask : set_mode

    task automatic set_pins(input logic [15:0] l, input logic [15:0] r);
        left_port_din  = l;
        right_port_din = r;
    endtask : set_pins
endmodule : plc_model

`default_nettype wire

// ==== sim/conveyor_motor_output_regs_test.sv ====
// self-checking bench of the conveyor motor output bank
`timescale 1ns/1ps
`default_nettype none

module conveyor_motor_output_regs_test
    import conveyor_out_pkg::*;
;
    logic        mclk, rst_n, plc_mode, wr_en;
    logic [15:0] wr_addr, wr_data, left_port_din, right_port_din;
    logic        stop_group_stopped_reg, left_port_dio_reg, left_pin4_out_reg;
    logic        left_pin3_out_reg, right_port_dio_reg, right_pin2_out_reg;
    logic        right_pin3_out_reg, aux_left_out_reg, aux_left_oe_n_reg;
    logic        aux_right_out_reg, aux_right_oe_n_reg, left_run_reg, left_reverse_reg;
    logic        right_run_reg, right_reverse_reg, fault_clear_reg;
    logic [1:0]  left_din_valid_reg, right_din_valid_reg;
    brake_e      left_brake_reg, right_brake_reg;
    follower_e   left_follow_reg, right_follow_reg;
    logic [15:0] left_speed, right_speed, left_accel, left_decel, right_accel, right_decel;
    int          fail_count = 0;
    int          cmp_count = 0;
    logic [15:0] rst_exp [17] = '{16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0000,
        16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
        16'h001e, 16'h001e, 16'h001e, 16'h001e, 16'h0000};
    // rows: offset, data written, observed field after the write
    logic [47:0] rows [57] = '{
        48'h0708_0001_0001, 48'h0708_0000_0001, 48'h0708_0003_0001, 48'h0708_0002_0000,
        48'h0709_8002_0005, 48'h0709_8005_0006, 48'h0709_7fff_0000, 48'h070a_8001_0005,
        48'h070a_8006_0006, 48'h070a_0005_0000, 48'h070b_0061_0001, 48'h070b_009e_000e,
        48'h070c_0101_0003, 48'h070c_0100_0002, 48'h070c_fefe_0000, 48'h070c_0001_0001,
        48'h070f_0101_0003, 48'h070f_0000_0000, 48'h070d_0001_0001, 48'h070d_0002_0001,
        48'h070d_0000_0000, 48'h0710_0003_0003, 48'h0710_0002_0002, 48'h0710_0001_0001,
        48'h0710_0004_0001, 48'h0710_0000_0000, 48'h070e_0002_0002, 48'h070e_0000_0002,
        48'h070e_0003_0003, 48'h070e_0004_0003, 48'h070e_0001_0001, 48'h0711_0003_0003,
        48'h0711_0002_0002, 48'h0711_0001_0001, 48'h0711_0000_0001, 48'h0711_0003_0003,
        48'h070f_0101_0003, 48'h0712_1234_1234, 48'h0712_0000_1234,
        48'h0713_ffff_ffff, 48'h0713_0000_ffff, 48'h0714_001d_001e, 48'h0714_2710_2710,
        48'h0714_2711_2710, 48'h0714_0000_2710, 48'h0714_001e_001e, 48'h0715_0001_0001,
        48'h0715_0000_0001, 48'h0715_2711_0001, 48'h0715_2710_2710, 48'h0716_0064_0064,
        48'h0716_0000_0064, 48'h0717_03e8_03e8, 48'h0717_0000_03e8, 48'h0718_0001_0001,
        48'h0718_0002_0001, 48'h0718_0000_0000};

    plc_model plc (.mclk, .plc_mode, .wr_en, .wr_addr, .wr_data, .left_port_din,
        .right_port_din);

    conveyor_motor_output_regs dut (.mclk, .rst_n, .plc_mode, .wr_en, .wr_addr, .wr_data,
        .left_port_din, .right_port_din, .stop_group_stopped_reg, .left_port_dio_reg,
        .left_pin4_out_reg, .left_pin3_out_reg, .right_port_dio_reg, .right_pin2_out_reg,
        .right_pin3_out_reg, .left_din_valid_reg, .right_din_valid_reg, .aux_left_out_reg,
        .aux_left_oe_n_reg, .aux_right_out_reg, .aux_right_oe_n_reg, .left_run_reg,
        .left_reverse_reg, .right_run_reg, .right_reverse_reg, .left_brake_reg,
        .right_brake_reg, .left_follow_reg, .right_follow_reg, .left_speed, .right_speed,
        .left_accel, .left_decel, .right_accel, .right_decel, .fault_clear_reg);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // field behind a word offset, packed from the low bit up
    function automatic logic [15:0] observe(input logic [15:0] a);
        case (a - 16'h0708)
            16'h0000: observe = {15'h0000, stop_group_stopped_reg};
            16'h0001: observe = {13'h0000, left_port_dio_reg, left_pin3_out_reg,
                                 left_pin4_out_reg};
            16'h0002: observe = {13'h0000, right_port_dio_reg, right_pin3_out_reg,
                                 right_pin2_out_reg};
            16'h0003: observe = {12'h000, aux_right_oe_n_reg, aux_right_out_reg,
                                 aux_left_oe_n_reg, aux_left_out_reg};
            16'h0004: observe = {14'h0000, left_reverse_reg, left_run_reg};
            16'h0005: observe = {14'h0000, left_brake_reg};
            16'h0006: observe = {14'h0000, left_follow_reg};
            16'h0007: observe = {14'h0000, right_reverse_reg, right_run_reg};
            16'h0008: observe = {14'h0000, right_brake_reg};
            16'h0009: observe = {14'h0000, right_follow_reg};
            16'h000a: observe = left_speed;
            16'h000b: observe = right_speed;
            16'h000c: observe = left_accel;
            16'h000d: observe = left_decel;
            16'h000e: observe = right_accel;
            16'h000f: observe = right_decel;
            16'h0010: observe = {15'h0000, fault_clear_reg};
            default:  observe = 16'h0000;
        endcase
    endfunction : observe

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_reset();
        for (int i = 0; i < 17; i++) begin
            check(observe(16'h0708 + 16'(i)), rst_exp[i]);
        end
        $display("test reset values done");
    endtask : check_reset

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check_reset();
        foreach (rows[i]) begin
            plc.write_word(rows[i][47:32], rows[i][31:16]);
            plc.idle();
            check(observe(rows[i][47:32]), rows[i][15:0]);
        end
        $display("test row table done");
        // writes outside controller mode and to unmapped offsets
        plc.set_mode(1'b0);
        plc.write_word(16'h0708, 16'h0001);
        plc.idle();
        check(observe(16'h0708), 16'h0000);
        plc.set_mode(1'b1);
        plc.write_word(16'h0707, 16'h0001);
        plc.write_word(16'h0719, 16'h0001);
        plc.idle();
        check(observe(16'h0708), 16'h0000);
        check(observe(16'h0718), 16'h0000);
        $display("test refused writes done");
        // back to back words
        plc.write_word(16'h0708, 16'h0001);
        plc.write_word(16'h0718, 16'h0001);
        plc.write_word(16'h0712, 16'h0bb8);
        plc.idle();
        check(observe(16'h0708), 16'h0001);
        check(observe(16'h0718), 16'h0001);
        check(observe(16'h0712), 16'h0bb8);
        $display("test back to back done");
        // pin status only in digital use, only bits 12 and 14
        plc.write_word(16'h0709, 16'h8000);
        plc.idle();
        plc.set_pins(16'hb5ff, 16'hffff);
        repeat (4) @(negedge mclk);
        check({14'h0000, left_din_valid_reg}, 16'h0001);
        check({14'h0000, right_din_valid_reg}, 16'h0000);
        plc.write_word(16'h070a, 16'h8000);
        plc.set_pins(16'h4a00, 16'hffff);
        repeat (4) @(negedge mclk);
        check({14'h0000, left_din_valid_reg}, 16'h0002);
        check({14'h0000, right_din_valid_reg}, 16'h0003);
        plc.idle();
        $display("test pin status done");
        // reset in mid run
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check_reset();
        print_verdict();
    end
endmodule : conveyor_motor_output_regs_test

`default_nettype wire
